// [core/cif_pkg.sv]
// constants and types shared by the card input format editor
`default_nettype none
package cif_pkg;
  localparam int unsigned BAND_LEN   = 315;
  localparam int unsigned COLS       = 80;
  localparam int unsigned PROG_BANDS = 5;
  localparam int unsigned WORD_W     = 44;
  localparam int unsigned ADDR_W     = 16;
  localparam logic [3:0]  OFF_CMD    = 4'h0;
  localparam logic [3:0]  OFF_BASE   = 4'h4;
  localparam logic [3:0]  OFF_STATUS = 4'h8;
  localparam logic [3:0]  OFF_CTRL   = 4'hC;
  localparam int          CMD_READ   = 0;
  localparam int          CMD_INHIB  = 1;
  localparam int          CMD_FLOAD  = 2;
  localparam int          CMD_BAND   = 4;
  localparam int          CTRL_CLR   = 0;
  localparam int          CTRL_FEED  = 1;
  localparam int          ST_BAND    = 8;
  localparam int          ST_WORDS   = 16;
  localparam logic [8:0]  POS_LAST   = 9'h13A;
  localparam logic [8:0]  NUM_LAST   = 9'h08E;
  localparam logic [7:0]  HALF_END   = 8'hA0;
  localparam logic [3:0]  SIGN_DIG   = 4'hA;
  localparam logic [3:0]  ROW_LAST   = 4'hB;
  localparam logic [3:0]  DIG_DEL    = 4'hF;
  localparam logic [1:0]  FD_ZERO    = 2'h0;
  localparam logic [1:0]  FD_XFER    = 2'h1;
  localparam logic [1:0]  FD_TWO     = 2'h2;
  localparam logic [4:0]  NUM_FIRST  = 5'h07;
  localparam logic [2:0]  BAND_NUM   = 3'h6;
  localparam logic [2:0]  BAND_REJ   = 3'h7;
  localparam logic [15:0] BASE_RST   = 16'h0000;
  typedef enum logic [2:0] {
    ST_WAIT, ST_ROWS, ST_EDIT, ST_READY, ST_XFER, ST_ALARM, ST_FL_REQ, ST_FL_WR
  } cif_state_t;
endpackage
`default_nettype wire

// [core/cif_input_editor.sv]
// card input format editor: card capture, band editing, transfer, AHB-Lite registers
`default_nettype none
module cif_input_editor
  import cif_pkg::*;
(
  input  wire logic                REF_CLK,
  input  wire logic                RESET,
  input  wire logic                HSEL,
  input  wire logic [31:0]         HADDR,
  input  wire logic [1:0]          HTRANS,
  input  wire logic                HWRITE,
  input  wire logic [2:0]          HSIZE,
  input  wire logic [31:0]         HWDATA,
  input  wire logic                HREADY,
  output logic      [31:0]         HRDATA,
  output logic                     HREADYOUT,
  output logic                     HRESP,
  input  wire logic                CARD_START,
  input  wire logic                CARD_ROW,
  input  wire logic [COLS-1:0]     CARD_COLUMN_INPUT,
  input  wire logic [7:0]          CARD_BAND_SELECT,
  input  wire logic [3:0]          SECONDARY_SELECT_LINE,
  output logic                     FEED_REQ,
  output logic                     ALARM_STOP,
  output logic                     UNIT_READY,
  output logic      [ADDR_W-1:0]   STORE_ADDR,
  output logic      [WORD_W-1:0]   STORE_WDATA,
  output logic                     STORE_WE,
  output logic                     STORE_RE,
  input  wire logic [WORD_W-1:0]   STORE_RDATA
);
  localparam int PIN_W = COLS + 14;

  cif_state_t        state_q;
  logic [2:0]        band_q;
  logic              numeric_q;
  logic              reject_q;
  logic              hold_q;
  logic              ready_q;
  logic              alarm_q;
  logic              inhib_q;
  logic              feed_q;
  logic [8:0]        pos_q;
  logic [7:0]        half_q;
  logic [3:0]        ec_q;
  logic [4:0]        words_q;
  logic [4:0]        flw_q;
  logic [2:0]        flb_q;
  logic [3:0]        row_q;
  logic [WORD_W-1:0] acc_q;
  logic [WORD_W-1:0] flbuf_q;
  logic [ADDR_W-1:0] waddr_q;
  logic [ADDR_W-1:0] st_addr_q;
  logic [WORD_W-1:0] st_wdata_q;
  logic              st_we_q;
  logic              st_re_q;
  logic              fl_wait_q;
  cif_state_t        ret_q;
  logic [3:0]        num_q  [COLS];
  logic [1:0]        zone_q [COLS];
  logic [3:0]        info_q [BAND_LEN];
  logic [1:0]        fmt_q  [PROG_BANDS][BAND_LEN];
  logic [PIN_W-1:0]  s1_q;
  logic [PIN_W-1:0]  s2_q;
  logic [1:0]        edge_q;
  logic              hready_q;
  logic [31:0]       hrdata_q;
  logic              cmd_pend_q;
  logic              wr_pend_q;
  logic [3:0]        wofs_q;
  logic [15:0]       base_q;
  logic              clr_q;
  logic              feed_cmd_q;

  function automatic logic reg_hit(input logic [31:0] a, input logic [3:0] ofs);
    reg_hit = (a[31:4] == 28'h0000000) && (a[3:0] == ofs);
  endfunction

  function automatic logic [2:0] pick_band(input logic [7:0] sel);
    pick_band = 3'h0;
    for (int b = 6; b >= 0; b--) begin
      if (sel[b]) pick_band = 3'(b + 1);
    end
  endfunction

  // pin synchroniser, second stage feeds everything
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      s1_q   <= '0;
      s2_q   <= '0;
      edge_q <= 2'h0;
    end else begin
      s1_q   <= {CARD_START, CARD_ROW, CARD_BAND_SELECT, SECONDARY_SELECT_LINE,
                 CARD_COLUMN_INPUT};
      s2_q   <= s1_q;
      edge_q <= s2_q[PIN_W-1:PIN_W-2];
    end
  end

  wire            start_p = s2_q[PIN_W-1] & ~edge_q[1];
  wire            row_p   = s2_q[PIN_W-2] & ~edge_q[0];
  wire [7:0]      bsel_w  = s2_q[COLS+11:COLS+4];
  wire [3:0]      sec_w   = s2_q[COLS+3:COLS];
  wire [COLS-1:0] cols_w  = s2_q[COLS-1:0];

  // weight 8 is hold, low weights a band
  wire [7:0] sec_dec = {sec_w[3],
                        7'(8'h01 << (sec_w[2:0] - 3'h1)) & {7{sec_w[2:0] != 3'h0}}};
  // band selects merged with secondary lines
  wire [7:0] sel_all = bsel_w | sec_dec;
  wire [2:0] band_w  = pick_band(sel_all);

  // halves alternate numeric, zone from column 80
  wire [6:0] hidx    = 7'(7'd79 - {1'b0, half_q[7:1]});
  wire [3:0] half_v  = (half_q >= HALF_END) ? 4'h0 :
                       (half_q[0] ? {2'h0, zone_q[hidx]} : num_q[hidx]);

  wire       first_f = (words_q == NUM_FIRST);
  // digit d of field, sign at lowest column
  wire [6:0] nidx    = first_f ? 7'(4'h2 - ec_q) :
                       7'(7'd79 - 7'(11 * int'(words_q)) - {3'h0, ec_q});
  // first field padded with high zeros
  // zero words past the first field
  wire       nzero   = (words_q > NUM_FIRST) || (first_f && ec_q > 4'h2);
  wire [3:0] ndig    = nzero ? 4'h0 : num_q[nidx];

  wire [1:0] fdig    = fmt_q[3'(band_q - 3'h1)][pos_q];
  logic [3:0] ed_w;
  always_comb begin
    ed_w = DIG_DEL;
    if (numeric_q) begin
      ed_w = (pos_q <= NUM_LAST) ? ndig : DIG_DEL;
    end else begin
      unique case (fdig)
        FD_ZERO: ed_w = 4'h0;
        FD_XFER: ed_w = half_v;
        FD_TWO:  ed_w = 4'h2;
        default: ed_w = DIG_DEL;
      endcase
    end
  end
  wire       consume = !numeric_q && fdig[0];
  wire [3:0] xdig    = info_q[pos_q];

  wire rd_cmd  = HWDATA[CMD_READ];
  wire fl_cmd  = HWDATA[CMD_FLOAD];
  wire idle_st = (state_q == ST_WAIT) || (state_q == ST_READY) || (state_q == ST_ALARM);
  wire rd_ok   = (state_q == ST_READY) || (state_q == ST_WAIT && hold_q && !start_p);
  wire fl_ok   = idle_st && !(state_q == ST_WAIT && start_p);
  // read waits for the card load unless a held card is waiting, which it releases
  wire cmd_ok  = rd_cmd ? rd_ok : (fl_cmd ? fl_ok : 1'b1);
  wire cmd_fire = cmd_pend_q && cmd_ok;
  wire rd_fire  = cmd_fire && rd_cmd;
  wire [2:0] fl_band = HWDATA[CMD_BAND+2:CMD_BAND];
  wire fl_fire  = cmd_fire && !rd_cmd && fl_cmd && fl_band != 3'h0 &&
                  fl_band <= 3'(PROG_BANDS);

  always_ff @(posedge REF_CLK) begin
    st_we_q <= 1'b0;
    st_re_q <= 1'b0;
    feed_q  <= 1'b0;
    if (RESET) begin
      state_q    <= ST_WAIT;
      ret_q      <= ST_WAIT;
      band_q     <= 3'h0;
      numeric_q  <= 1'b0;
      reject_q   <= 1'b0;
      hold_q     <= 1'b0;
      ready_q    <= 1'b0;
      alarm_q    <= 1'b0;
      inhib_q    <= 1'b0;
      pos_q      <= 9'h000;
      half_q     <= 8'h00;
      ec_q       <= 4'h0;
      words_q    <= 5'h00;
      flw_q      <= 5'h00;
      flb_q      <= 3'h0;
      row_q      <= 4'h0;
      fl_wait_q  <= 1'b0;
      acc_q      <= '0;
      flbuf_q    <= '0;
      waddr_q    <= '0;
      st_addr_q  <= '0;
      st_wdata_q <= '0;
    end else if (fl_fire) begin
      ret_q   <= state_q;
      state_q <= ST_FL_REQ;
      flb_q   <= fl_band;
      flw_q   <= 5'h00;
      pos_q   <= 9'h000;
      ec_q    <= 4'h0;
    end else begin
      unique case (state_q)
        ST_WAIT: begin
          if (rd_fire) begin
            hold_q <= 1'b0;
            feed_q <= !HWDATA[CMD_INHIB];
          end else if (start_p && !hold_q) begin
            ready_q   <= 1'b0;
            band_q    <= band_w;
            numeric_q <= band_w >= BAND_NUM;
            reject_q  <= band_w == BAND_REJ;
            // band 8 holds the next card
            hold_q    <= sel_all[7] && band_w != 3'h0;
            row_q     <= 4'h0;
            for (int c = 0; c < COLS; c++) begin
              num_q[c]  <= 4'h0;
              zone_q[c] <= 2'h0;
            end
            if (band_w == 3'h0) begin
              alarm_q <= 1'b1;
              state_q <= ST_ALARM;
            end else begin
              state_q <= ST_ROWS;
            end
          end else if (feed_cmd_q) begin
            feed_q <= 1'b1;
          end
        end
        ST_ROWS: begin
          if (row_p) begin
            for (int c = 0; c < COLS; c++) begin
              if (cols_w[c]) begin
                if (row_q == 4'h0) zone_q[c] <= 2'h1;
                else if (row_q == 4'h1) zone_q[c] <= 2'h2;
                else num_q[c] <= 4'(row_q - 4'h2);
              end
            end
            row_q <= row_q + 4'h1;
            if (row_q == ROW_LAST) begin
              state_q <= ST_EDIT;
              pos_q   <= 9'h000;
              half_q  <= 8'h00;
              ec_q    <= 4'h0;
              words_q <= 5'h00;
            end
          end
        end
        ST_EDIT: begin
          info_q[pos_q] <= ed_w;
          if (consume) half_q <= half_q + 8'h01;
          if (ed_w != DIG_DEL) begin
            ec_q <= (ec_q == SIGN_DIG) ? 4'h0 : ec_q + 4'h1;
            if (ec_q == SIGN_DIG) words_q <= words_q + 5'h01;
          end
          if (pos_q == POS_LAST) begin
            if (reject_q) begin
              state_q <= ST_WAIT;
              feed_q  <= !hold_q;
            end else begin
              // ready once the load is done
              ready_q <= 1'b1;
              state_q <= ST_READY;
            end
          end else begin
            pos_q <= pos_q + 9'h001;
          end
        end
        ST_READY: begin
          if (rd_fire) begin
            ready_q <= 1'b0;
            hold_q  <= 1'b0;
            inhib_q <= HWDATA[CMD_INHIB];
            pos_q   <= 9'h000;
            ec_q    <= 4'h0;
            waddr_q <= base_q + 16'(words_q) - 16'h0001;
            state_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (xdig != DIG_DEL) begin
            acc_q <= {xdig, acc_q[WORD_W-1:4]};
            ec_q  <= ec_q + 4'h1;
            if (ec_q == SIGN_DIG) begin
              st_wdata_q <= {xdig, acc_q[WORD_W-1:4]};
              st_addr_q  <= waddr_q;
              st_we_q    <= 1'b1;
              waddr_q    <= waddr_q - 16'h0001;
              ec_q       <= 4'h0;
            end
          end
          if (pos_q == POS_LAST) begin
            state_q <= ST_WAIT;
            feed_q  <= !inhib_q;
          end else begin
            pos_q <= pos_q + 9'h001;
          end
        end
        ST_ALARM: begin
          if (clr_q) begin
            alarm_q <= 1'b0;
            state_q <= ST_WAIT;
          end
        end
        ST_FL_REQ: begin
          if (!fl_wait_q) begin
            st_addr_q <= base_q + 16'(flw_q);
            st_re_q   <= 1'b1;
            fl_wait_q <= 1'b1;
          end else if (!st_re_q) begin
            flbuf_q   <= STORE_RDATA;
            fl_wait_q <= 1'b0;
            state_q   <= ST_FL_WR;
          end
        end
        ST_FL_WR: begin
          fmt_q[3'(flb_q - 3'h1)][pos_q] <= flbuf_q[1:0];
          flbuf_q <= flbuf_q >> 4;
          if (pos_q == POS_LAST) begin
            state_q <= ret_q;
          end else begin
            pos_q <= pos_q + 9'h001;
            ec_q  <= (ec_q == SIGN_DIG) ? 4'h0 : ec_q + 4'h1;
            if (ec_q == SIGN_DIG) begin
              flw_q   <= flw_q + 5'h01;
              state_q <= ST_FL_REQ;
            end
          end
        end
        default: state_q <= ST_WAIT;
      endcase
    end
  end

  wire a_ph    = HSEL && HTRANS[1] && HREADY;
  wire cmd_sel = reg_hit(HADDR, OFF_CMD);
  wire busy_w  = !idle_st;
  // status word: ready bit 0, hold 1, alarm 2, reject 3, busy 4, band at 8, word count at 16
  wire [31:0] status_w = {11'h000, words_q, 5'h00, band_q, 3'h0, busy_w,
                          reject_q, alarm_q, hold_q, ready_q};
  wire [31:0] rd_w = reg_hit(HADDR, OFF_STATUS) ? status_w :
                     reg_hit(HADDR, OFF_BASE) ? {16'h0000, base_q} : 32'h00000000;

  always_ff @(posedge REF_CLK) begin
    clr_q      <= 1'b0;
    feed_cmd_q <= 1'b0;
    if (RESET) begin
      hready_q   <= 1'b1;
      hrdata_q   <= 32'h00000000;
      cmd_pend_q <= 1'b0;
      wr_pend_q  <= 1'b0;
      wofs_q     <= 4'h0;
      base_q     <= BASE_RST;
    end else begin
      wr_pend_q <= a_ph && HWRITE && !cmd_sel && HADDR[31:4] == 28'h0000000;
      if (a_ph) begin
        hrdata_q <= HWRITE ? 32'h00000000 : rd_w;
        wofs_q   <= HADDR[3:0];
        if (HWRITE && cmd_sel) begin
          cmd_pend_q <= 1'b1;
          hready_q   <= 1'b0;
        end
      end
      if (wr_pend_q) begin
        if (wofs_q == OFF_BASE) base_q <= HWDATA[15:0];
        if (wofs_q == OFF_CTRL) begin
          clr_q      <= HWDATA[CTRL_CLR];
          feed_cmd_q <= HWDATA[CTRL_FEED];
        end
      end
      if (cmd_fire) begin
        cmd_pend_q <= 1'b0;
        hready_q   <= 1'b1;
      end
    end
  end

  assign HRDATA      = hrdata_q;
  assign HREADYOUT   = hready_q;
  assign HRESP       = 1'b0;
  assign FEED_REQ    = feed_q;
  assign ALARM_STOP  = alarm_q;
  assign UNIT_READY  = ready_q;
  assign STORE_ADDR  = st_addr_q;
  assign STORE_WDATA = st_wdata_q;
  assign STORE_WE    = st_we_q;
  assign STORE_RE    = st_re_q;

  property p_stall_read;
    @(posedge REF_CLK) disable iff (RESET)
      cmd_pend_q && HWDATA[CMD_READ] && state_q == ST_ROWS |-> !hready_q ##1 !hready_q;
  endproperty
  a_stall_read: assert property (p_stall_read) else $error("read not stalled");
  property p_ready_rise;
    @(posedge REF_CLK) disable iff (RESET)
      $rose(ready_q) |-> $past(state_q) == ST_EDIT && !reject_q;
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready without load");
  property p_reload;
    @(posedge REF_CLK) disable iff (RESET)
      state_q == ST_XFER && pos_q == POS_LAST && !inhib_q |=> FEED_REQ && state_q == ST_WAIT;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after read");
  property p_inhibit;
    @(posedge REF_CLK) disable iff (RESET)
      state_q == ST_XFER && pos_q == POS_LAST && inhib_q |=> !FEED_REQ;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("feed despite inhibit");
  property p_hold_clear;
    @(posedge REF_CLK) disable iff (RESET)
      rd_fire && !fl_fire |=> !hold_q;
  endproperty
  a_hold_clear: assert property (p_hold_clear) else $error("hold not cleared");
  property p_no_format;
    @(posedge REF_CLK) disable iff (RESET)
      state_q == ST_WAIT && start_p && !hold_q && !cmd_fire && sel_all[6:0] == 7'h00
      |=> ALARM_STOP && state_q == ST_ALARM;
  endproperty
  a_no_format: assert property (p_no_format) else $error("missing no-format alarm");
  property p_reject;
    @(posedge REF_CLK) disable iff (RESET)
      state_q == ST_EDIT && pos_q == POS_LAST && reject_q
      |=> FEED_REQ == !hold_q && !UNIT_READY;
  endproperty
  a_reject: assert property (p_reject) else $error("reject handling wrong");
  property p_sign_word;
    @(posedge REF_CLK) disable iff (RESET)
      STORE_WE |-> $past(ec_q) == SIGN_DIG && $past(state_q) == ST_XFER;
  endproperty
  a_sign_word: assert property (p_sign_word) else $error("word not at eleventh digit");
  // last stored address of this transfer
  logic [ADDR_W-1:0] prev_addr_q;
  logic              prev_ok_q;
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      prev_addr_q <= '0;
      prev_ok_q   <= 1'b0;
    end else if (state_q == ST_READY) begin
      prev_ok_q <= 1'b0;
    end else if (STORE_WE) begin
      prev_addr_q <= STORE_ADDR;
      prev_ok_q   <= 1'b1;
    end
  end
  property p_consecutive;
    @(posedge REF_CLK) disable iff (RESET)
      STORE_WE && prev_ok_q |-> STORE_ADDR == prev_addr_q - 16'h0001;
  endproperty
  a_consecutive: assert property (p_consecutive) else $error("words not consecutive");
  property p_held_card;
    @(posedge REF_CLK) disable iff (RESET)
      state_q == ST_WAIT && hold_q && start_p && !cmd_fire |=> state_q == ST_WAIT;
  endproperty
  a_held_card: assert property (p_held_card) else $error("held card loaded");
endmodule
`default_nettype wire

// [verification/cif_store_model.sv]
// processor storage model behind the editor's storage port
`default_nettype none
module cif_store_model
  import cif_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [WORD_W-1:0] wdata,
  input  wire logic              we,
  input  wire logic              re,
  output logic      [WORD_W-1:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [WORD_W-1:0] mem [0:1023];
  initial begin
    rdata = '0;
    for (int i = 0; i < 1024; i++) mem[i] = 44'hBBBBBBBBBBB;
  end
  // words stored and served
  // outside a read the data lines change every cycle
  always @(posedge clk) begin
    if (we) mem[addr[9:0]] <= wdata;
    rdata <= re ? mem[addr[9:0]] : ~rdata;
  end
endmodule
`default_nettype wire

// [verification/tb.sv]
// testbench for the card input format editor
`default_nettype none
module tb
  import cif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_CMD = {4'h0, OFF_CMD};
  localparam logic [7:0] A_BASE = {4'h0, OFF_BASE};
  localparam logic [7:0] A_ST = {4'h0, OFF_STATUS};
  localparam logic [7:0] A_CTRL = {4'h0, OFF_CTRL};
  logic              ref_clk, reset, hsel, hwrite, hreadyout, hresp, card_start, card_row;
  logic              feed_req, alarm_stop, unit_ready, store_we, store_re, rdy_q;
  logic [31:0]       haddr, hwdata, hrdata, rv;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [79:0]       col_in;
  logic [7:0]        band_sel;
  logic [3:0]        sec_sel;
  logic [ADDR_W-1:0] store_addr;
  logic [WORD_W-1:0] store_wdata, store_rdata;
  logic [79:0]       crd [12];
  logic [WORD_W-1:0] exp_w [13];
  int                fail_count, cmp_count, feeds, rises, f0, r0;

  cif_input_editor DUT (
    .REF_CLK(ref_clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .CARD_START(card_start), .CARD_ROW(card_row),
    .CARD_COLUMN_INPUT(col_in), .CARD_BAND_SELECT(band_sel),
    .SECONDARY_SELECT_LINE(sec_sel), .FEED_REQ(feed_req), .ALARM_STOP(alarm_stop),
    .UNIT_READY(unit_ready), .STORE_ADDR(store_addr), .STORE_WDATA(store_wdata),
    .STORE_WE(store_we), .STORE_RE(store_re), .STORE_RDATA(store_rdata)
  );
  cif_store_model u_mem (
    .clk(ref_clk), .addr(store_addr), .wdata(store_wdata), .we(store_we), .re(store_re),
    .rdata(store_rdata)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    rdy_q <= unit_ready;
    if (feed_req === 1'b1) feeds <= feeds + 1;
    if (unit_ready === 1'b1 && rdy_q === 1'b0) rises <= rises + 1;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // single transfer: address phase held until ready, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    ahb(1'b0, a, 32'h0);
  endtask

  task automatic wait_idle();
    rv = 32'h10;
    for (int i = 0; i < 3000 && rv[4] !== 1'b0; i++) rd(A_ST);
    cyc(4);
  endtask

  // row index 0 is the 12 zone, 1 the 11 zone, digit d is d+2
  function automatic void punch(input int col, input int row);
    crd[row][col-1] = 1'b1;
  endfunction

  task automatic card(input logic [7:0] sel, input logic [3:0] sec);
    band_sel <= sel;
    sec_sel <= sec;
    card_start <= 1'b1;
    cyc(4);
    for (int r = 0; r < 12; r++) begin
      col_in <= crd[r];
      cyc(2);
      card_row <= 1'b1;
      cyc(2);
      card_row <= 1'b0;
      cyc(2);
    end
    card_start <= 1'b0;
    band_sel <= 8'h00;
    sec_sel <= 4'h0;
    col_in <= ~crd[11];
    foreach (crd[i]) crd[i] = '0;
  endtask

  initial begin
    {hsel, hwrite, htrans, haddr, hwdata, card_start, card_row, rdy_q} = '0;
    {col_in, band_sel, sec_sel, fail_count, cmp_count, feeds, rises} = '0;
    hsize = 3'h2;
    reset = 1'b1;
    foreach (crd[i]) crd[i] = '0;
    cyc(20);
    reset <= 1'b0;
    rd(A_ST);
    chk("status", 44'h0, {12'h0, rv & 32'h1F});
    rd(A_BASE);
    chk("base", {28'h0, BASE_RST}, {12'h0, rv});
    wr(8'h10, 32'hFFFFFFFF);
    rd(8'h10);
    chk("unmapped", 44'h0, {12'h0, rv});
    chk("hresp", 44'h0, {43'h0, hresp});
    for (int i = 0; i < 29; i++)
      u_mem.mem[256+i] = i == 0 ? 44'h66666666664 : i < 3 ? 44'h55555555555 : 44'h77777777777;
    wr(A_BASE, 32'h100);
    wr(A_CMD, 32'h14);
    wait_idle();
    punch(80, 9);
    punch(79, 5);
    punch(79, 0);
    punch(75, 11);
    punch(72, 6);
    wr(A_BASE, 32'h200);
    f0 = feeds;
    fork
      card(8'h01, 4'h0);
      begin
        cyc(30);
        wr(A_CMD, 32'h1);
        chk("stall", 44'd1, 44'(rises));
      end
    join
    wait_idle();
    chk("w2", 44'h22222222220, u_mem.mem[514]);
    chk("w1", 44'h90000001307, u_mem.mem[513]);
    chk("w0", 44'h00000400000, u_mem.mem[512]);
    chk("w3", 44'hBBBBBBBBBBB, u_mem.mem[515]);
    chk("feed", 44'(f0 + 1), 44'(feeds));
    for (int i = 0; i < 14; i++) u_mem.mem[512+i] = 44'hBBBBBBBBBBB;
    punch(80, 3);
    punch(70, 10);
    punch(70, 0);
    punch(3, 4);
    punch(1, 7);
    punch(14, 8);
    card(8'h00, 4'h6);
    for (int i = 0; i < 2000 && unit_ready !== 1'b1; i++) cyc(1);
    rd(A_ST);
    chk("ready", 44'h1, {43'h0, rv[0]});
    chk("words", 44'd13, {39'h0, rv[20:16]});
    chk("band", 44'd6, {41'h0, rv[10:8]});
    f0 = feeds;
    wr(A_CMD, 32'h3);
    chk("rdy_clr", 44'h0, {43'h0, unit_ready});
    wait_idle();
    chk("inhibit", 44'(f0), 44'(feeds));
    foreach (exp_w[i]) exp_w[i] = '0;
    exp_w[12] = 44'h80000000001;
    exp_w[6] = 44'h6;
    exp_w[5] = 44'h502;
    for (int i = 0; i < 13; i++) chk("num", exp_w[i], u_mem.mem[512+i]);
    chk("num_end", 44'hBBBBBBBBBBB, u_mem.mem[525]);
    card(8'h80, 4'h0);
    for (int i = 0; i < 2000 && alarm_stop !== 1'b1; i++) cyc(1);
    rd(A_ST);
    chk("alarm", 44'h1, {43'h0, rv[2]});
    wr(A_CTRL, 32'h1);
    cyc(2);
    chk("alarm_clr", 44'h0, {43'h0, alarm_stop});
    f0 = feeds;
    card(8'h40, 4'h0);
    for (int i = 0; i < 2000 && feeds == f0; i++) cyc(1);
    chk("rej_feed", 44'(f0 + 1), 44'(feeds));
    rd(A_ST);
    chk("rej_st", 44'h8, {40'h0, rv[3:0]});
    f0 = feeds;
    r0 = rises;
    card(8'h00, 4'hF);
    cyc(800);
    rd(A_ST);
    chk("hold", 44'h1, {43'h0, rv[1]});
    chk("hold_feed", 44'(f0), 44'(feeds));
    card(8'h01, 4'h0);
    cyc(800);
    chk("held", 44'(r0), 44'(rises));
    wr(A_CMD, 32'h1);
    for (int i = 0; i < 1000 && feeds == f0; i++) cyc(1);
    rd(A_ST);
    chk("unhold", 44'h0, {43'h0, rv[1]});
    chk("unhold_feed", 44'(f0 + 1), 44'(feeds));
    finish_test();
  end

  initial begin
    cyc(40000);
    fail_count++;
    finish_test();
  end
endmodule
`default_nettype wire
